// ### status_flags.sv
// Status mask decode and sticky scaling and limit flags, register port
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
module status_flags
  import sr_flags_pkg::*;
(
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  input  wire logic                             proc_rst,
  input  wire logic [sr_flags_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [sr_flags_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [sr_flags_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [sr_flags_pkg::ACC_W-1:0]   acc_a,
  input  wire logic [sr_flags_pkg::ACC_W-1:0]   acc_b,
  input  wire logic                             move_x_side_data_bus,
  input  wire logic                             move_y_side_data_bus,
  input  wire logic                             acc_read,
  input  wire logic                             limiter_active,
  input  wire logic                             overflow_flag,
  input  wire logic                             sat_event,
  output logic                                  irq,
  output logic      [3:0]                       exception_priority_level,
  output logic                                  mask_level_high,
  output logic                                  mask_level_low,
  output logic                                  scale_select_high,
  output logic                                  scale_select_low,
  output logic                                  sat_mode,
  output logic                                  scale_flag,
  output logic                                  limit_flag
);

  import sr_flags_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Registers

  logic [1:0]        mask_ff;
  logic [1:0]        sel_ff;
  logic              sat_ff;
  logic [EV_W-1:0]   ist_ff;
  logic [EV_W-1:0]   imsk_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic [1:0]        nxt_mask;
  logic [1:0]        nxt_sel;
  logic              nxt_sat;
  logic [EV_W-1:0]   nxt_ist;
  logic [EV_W-1:0]   nxt_imsk;
  logic [DATA_W-1:0] nxt_rdata;

  status_if st ();

  //////////////////////////////////////////////////////////////////////
  // Address decode

  logic wr_sr;
  logic wr_fclr;
  logic wr_cfg;
  logic wr_ist;
  logic wr_imsk;

  assign wr_sr   = reg_wr && (reg_addr == OFS_SR);
  assign wr_fclr = reg_wr && (reg_addr == OFS_FCLR);
  assign wr_cfg  = reg_wr && (reg_addr == OFS_CFG);
  assign wr_ist  = reg_wr && (reg_addr == OFS_IST);
  assign wr_imsk = reg_wr && (reg_addr == OFS_IMSK);

  //////////////////////////////////////////////////////////////////////
  // Mode and mask fields

  // Soft reset does not touch the mask; only hardware reset sets it
  assign nxt_mask = wr_sr ? reg_wdata[MASK_LO+1:MASK_LO] : mask_ff;
  assign nxt_sel  = wr_sr ? reg_wdata[SEL_LO+1:SEL_LO] : sel_ff;
  assign nxt_sat  = wr_cfg ? reg_wdata[SAT_POS] : sat_ff;
  assign nxt_imsk = wr_imsk ? reg_wdata[EV_W-1:0] : imsk_ff;

  // Hardware reset loads the highest masking level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= MASK_RST;
      sel_ff  <= SEL_RST;
      sat_ff  <= SAT_RST;
      imsk_ff <= IMSK_RST;
    end else begin
      mask_ff <= nxt_mask;
      sel_ff  <= nxt_sel;
      sat_ff  <= nxt_sat;
      imsk_ff <= nxt_imsk;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Flag set conditions

  logic acc_move;
  logic hit_a;
  logic hit_b;
  logic clamp_move;
  logic sat_hit;

  // Any result leaving A or B for either data bus
  assign acc_move   = move_x_side_data_bus | move_y_side_data_bus;

  // Both accumulators are tested whichever one moved
  assign hit_a      = scale_hit(acc_a, sel_ff);
  assign hit_b      = scale_hit(acc_b, sel_ff);

  // A clamp counts when a move reads an accumulator
  assign clamp_move = limiter_active & (acc_read | acc_move);

  // Saturation is ignored outside saturation mode
  assign sat_hit    = sat_ff & sat_event;

  assign st.mask     = mask_ff;
  assign st.s_set    = acc_move & (hit_a | hit_b);
  assign st.l_set    = overflow_flag | clamp_move | sat_hit;
  assign st.s_clr    = wr_fclr & reg_wdata[SCALE_POS];
  assign st.l_clr    = wr_fclr & reg_wdata[LIMIT_POS];
  assign st.soft_rst = proc_rst;

  mask_decode u_mask_decode (
    .sys_clk (sys_clk),
    .rst     (rst),
    .st      (st.dec)
  );

  sticky_flags u_sticky_flags (
    .sys_clk (sys_clk),
    .rst     (rst),
    .st      (st.flg)
  );

  //////////////////////////////////////////////////////////////////////
  // Interrupt status

  logic [EV_W-1:0] ev_now;
  logic [EV_W-1:0] ist_w1c;

  // Events are flag sets, so a repeat set while sticky still pulses
  assign ev_now[EV_SCALE] = st.s_set;
  assign ev_now[EV_LIMIT] = st.l_set;
  assign ist_w1c = wr_ist ? reg_wdata[EV_W-1:0] : {EV_W{1'b0}};

  // A new event beats a write-one clear in the same cycle
  assign nxt_ist = ev_now | (ist_ff & ~ist_w1c);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ist_ff <= {EV_W{1'b0}};
    end else begin
      ist_ff <= nxt_ist;
    end
  end

  assign irq = |(ist_ff & imsk_ff);

  //////////////////////////////////////////////////////////////////////
  // Read path

  logic [DATA_W-1:0] sr_word;
  logic [DATA_W-1:0] rd_word;

  assign sr_word = {{(DATA_W-SEL_LO-2){1'b0}}, sel_ff, mask_ff,
                    st.s_flag, st.l_flag, {LIMIT_POS{1'b0}}};

  // Unmapped offsets read as zero
  always_comb begin
    unique case (reg_addr)
      OFS_SR:   rd_word = sr_word;
      OFS_CFG:  rd_word = {{(DATA_W-1){1'b0}}, sat_ff};
      OFS_IST:  rd_word = {{(DATA_W-EV_W){1'b0}}, ist_ff};
      OFS_IMSK: rd_word = {{(DATA_W-EV_W){1'b0}}, imsk_ff};
      OFS_PERM: rd_word = {{(DATA_W-4){1'b0}}, st.permit};
      default:  rd_word = {DATA_W{1'b0}};
    endcase
  end

  // Data stand only in the cycle after the strobe
  assign nxt_rdata = reg_rd ? rd_word : {DATA_W{1'b0}};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= {DATA_W{1'b0}};
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata                = rdata_ff;
  assign exception_priority_level = st.permit;
  assign mask_level_high          = mask_ff[1];
  assign mask_level_low           = mask_ff[0];
  assign scale_select_high        = sel_ff[1];
  assign scale_select_low         = sel_ff[0];
  assign sat_mode                 = sat_ff;
  assign scale_flag               = st.s_flag;
  assign limit_flag               = st.l_flag;

  //////////////////////////////////////////////////////////////////////
  // Checks

  a_mask_hw_reset : assert property (
    @(posedge sys_clk)
    rst |=> mask_ff == MASK_RST ##1 exception_priority_level == 4'h8)
    else $error("hardware reset did not raise the mask");

  a_mask_soft_keep : assert property (
    @(posedge sys_clk) disable iff (rst)
    proc_rst && !wr_sr |=> $stable(mask_ff))
    else $error("soft reset changed the mask");

  a_scale_on_move : assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_move && (hit_a || hit_b) && !proc_rst |=> scale_flag)
    else $error("scaling flag not set by an accumulator move");

  a_scale_no_move : assert property (
    @(posedge sys_clk) disable iff (rst)
    !acc_move && !scale_flag |=> !scale_flag)
    else $error("scaling flag set without a move");

  a_scale_mode_pair : assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_move && !proc_rst && !scale_flag && sel_ff == SC_DOWN &&
    (acc_a[PAIR_DOWN+1] != acc_a[PAIR_DOWN]) |=> scale_flag)
    else $error("scale down mode ignored its bit pair");

  a_scale_rsvd : assert property (
    @(posedge sys_clk) disable iff (rst)
    sel_ff == SC_RSVD && !scale_flag |=> !scale_flag)
    else $error("reserved scaling mode set the flag");

  a_scale_band : assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_move && sel_ff == SC_NONE && !scale_flag &&
    acc_a[PAIR_NONE+1] == acc_a[PAIR_NONE] &&
    acc_b[PAIR_NONE+1] == acc_b[PAIR_NONE] |=> !scale_flag)
    else $error("scaling flag set outside the magnitude band");

  a_limit_ovf : assert property (
    @(posedge sys_clk) disable iff (rst)
    overflow_flag && !proc_rst |=> limit_flag && ist_ff[EV_LIMIT])
    else $error("overflow did not latch the limit flag");

  a_limit_sat_on : assert property (
    @(posedge sys_clk) disable iff (rst)
    sat_mode && sat_event && !proc_rst |=> limit_flag)
    else $error("saturation missed in saturation mode");

  a_limit_sat_off : assert property (
    @(posedge sys_clk) disable iff (rst)
    !sat_mode && !overflow_flag && !limiter_active && !limit_flag
    |=> !limit_flag)
    else $error("limit flag set with no cause");

  a_limit_clr : assert property (
    @(posedge sys_clk) disable iff (rst)
    proc_rst |=> !limit_flag && !scale_flag)
    else $error("processor reset left a sticky flag set");

  a_limit_move : assert property (
    @(posedge sys_clk) disable iff (rst)
    limiter_active && acc_read && !proc_rst |=> limit_flag)
    else $error("clamp on an accumulator read not latched");

  a_read_slot : assert property (
    @(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == {DATA_W{1'b0}})
    else $error("read data outside its slot");

  // Each mask code against its literal level set, one cycle after the mask
  a_mask_code_zero : assert property (
    @(posedge sys_clk) disable iff (rst)
    mask_ff == 2'h0 |=> exception_priority_level == 4'hf)
    else $error("mask code zero did not permit every level");

  a_mask_code_one : assert property (
    @(posedge sys_clk) disable iff (rst)
    mask_ff == 2'h1 |=> exception_priority_level == 4'he)
    else $error("mask code one did not block level zero");

  a_mask_code_two : assert property (
    @(posedge sys_clk) disable iff (rst)
    mask_ff == 2'h2 |=> exception_priority_level == 4'hc)
    else $error("mask code two did not block levels zero and one");

  a_mask_code_three : assert property (
    @(posedge sys_clk) disable iff (rst)
    mask_ff == 2'h3 |=> exception_priority_level == 4'h8)
    else $error("mask code three let a low level through");

  // The other bit pairs and accumulator B, so a wrong pair cannot hide
  a_scale_none_pair : assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_move && !proc_rst && sel_ff == SC_NONE &&
    (acc_b[PAIR_NONE+1] != acc_b[PAIR_NONE]) |=> scale_flag)
    else $error("no scaling mode ignored its bit pair");

  a_scale_up_pair : assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_move && !proc_rst && sel_ff == SC_UP &&
    (acc_a[PAIR_UP+1] != acc_a[PAIR_UP]) |=> scale_flag)
    else $error("scale up mode ignored its bit pair");

  a_scale_b_down : assert property (
    @(posedge sys_clk) disable iff (rst)
    acc_move && !proc_rst && sel_ff == SC_DOWN &&
    (acc_b[PAIR_DOWN+1] != acc_b[PAIR_DOWN]) |=> scale_flag)
    else $error("scale down mode ignored accumulator b");

  a_scale_clear : assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_fclr && reg_wdata[SCALE_POS] && !st.s_set |=> !scale_flag)
    else $error("explicit clear left the scaling flag set");

  a_limit_clear : assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_fclr && reg_wdata[LIMIT_POS] && !st.l_set |=> !limit_flag)
    else $error("explicit clear left the limit flag set");

  a_limit_clamp_move : assert property (
    @(posedge sys_clk) disable iff (rst)
    limiter_active && acc_move && !proc_rst |=> limit_flag)
    else $error("clamp on an accumulator move not latched");

  // Events reach the status word even while the flag is already set
  a_scale_event : assert property (
    @(posedge sys_clk) disable iff (rst)
    st.s_set |=> ist_ff[EV_SCALE])
    else $error("scaling event missing from interrupt status");

  a_limit_event : assert property (
    @(posedge sys_clk) disable iff (rst)
    st.l_set |=> ist_ff[EV_LIMIT])
    else $error("limit event missing from interrupt status");

  a_sat_mode_write : assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_cfg |=> sat_mode == $past(reg_wdata[SAT_POS]))
    else $error("saturation mode did not take the written bit");

  a_sel_soft_keep : assert property (
    @(posedge sys_clk) disable iff (rst)
    proc_rst && !wr_sr |=> $stable(sel_ff))
    else $error("soft reset changed the scaling select");

endmodule : status_flags

// ### sr_flags_pkg.sv
// Constants, types and helpers for the status mask and sticky flags
//
// Contract
// - Hardware reset sets mask; soft reset keeps
// - Accumulator move to bus sets scaling flag
// - Scaling flag sticky until reset or clear
// - Scaling mode chooses the tested bit pair
// - Set on magnitude quarter to three quarters
// - Bit pair per mode, ORed with previous
// - Overflow or limiter sets limit flag
// - Saturation sets limit only in saturation mode
// - Limit flag latches until reset or clear
// - Accumulator reads by moves update limit
package sr_flags_pkg;

  localparam int ACC_W  = 56;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_SR   = 8'h00;
  localparam logic [7:0] OFS_FCLR = 8'h04;
  localparam logic [7:0] OFS_CFG  = 8'h08;
  localparam logic [7:0] OFS_IST  = 8'h0c;
  localparam logic [7:0] OFS_IMSK = 8'h10;
  localparam logic [7:0] OFS_PERM = 8'h14;

  // Field positions
  localparam int LIMIT_POS = 6;
  localparam int SCALE_POS = 7;
  localparam int MASK_LO   = 8;
  localparam int SEL_LO    = 10;
  localparam int SAT_POS   = 0;
  localparam int EV_SCALE  = 0;
  localparam int EV_LIMIT  = 1;
  localparam int EV_W      = 2;

  // Low bit of the accumulator pair tested in each scaling mode
  localparam int PAIR_NONE = 45;
  localparam int PAIR_DOWN = 46;
  localparam int PAIR_UP   = 44;

  // Reset values
  localparam logic [1:0]      MASK_RST = 2'h3;
  localparam logic [1:0]      SEL_RST  = 2'h0;
  localparam logic            SAT_RST  = 1'b0;
  localparam logic [EV_W-1:0] IMSK_RST = 2'h0;

  typedef enum logic [1:0] {
    SC_NONE = 2'h0,
    SC_DOWN = 2'h1,
    SC_UP   = 2'h2,
    SC_RSVD = 2'h3
  } scale_mode_t;

  // Priority levels let through by a mask code, one bit per level
  function automatic logic [3:0] permit_of(input logic [1:0] code);
    permit_of = 4'hf << code;
  endfunction : permit_of

  // Scaling test of one accumulator; reserved mode never sets
  function automatic logic scale_hit(input logic [ACC_W-1:0] acc,
                                     input logic [1:0]       mode);
    case (mode)
      SC_NONE: scale_hit = acc[PAIR_NONE+1] ^ acc[PAIR_NONE];
      SC_DOWN: scale_hit = acc[PAIR_DOWN+1] ^ acc[PAIR_DOWN];
      SC_UP:   scale_hit = acc[PAIR_UP+1] ^ acc[PAIR_UP];
      default: scale_hit = 1'b0;
    endcase
  endfunction : scale_hit

endpackage : sr_flags_pkg

// ### status_if.sv
// Interface between the status core and its decode and flag helpers
`timescale 1ns/1ps
interface status_if;
  logic [1:0] mask;
  logic [3:0] permit;
  logic       s_set;
  logic       l_set;
  logic       s_clr;
  logic       l_clr;
  logic       soft_rst;
  logic       s_flag;
  logic       l_flag;
  modport dec (input mask, output permit);
  modport flg (input s_set, l_set, s_clr, l_clr, soft_rst,
               output s_flag, l_flag);
  modport core (output mask, s_set, l_set, s_clr, l_clr, soft_rst,
                input permit, s_flag, l_flag);
endinterface : status_if

// ### mask_decode.sv
// Registered decode of the mask code into permitted priority levels
`timescale 1ns/1ps
module mask_decode
  import sr_flags_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  status_if.dec     st
);

  // Registered so the level outputs never glitch on a mask write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st.permit <= permit_of(MASK_RST);
    end else begin
      st.permit <= permit_of(st.mask);
    end
  end

  a_permit_map : assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 st.permit == permit_of($past(st.mask)))
    else $error("permitted levels do not follow the mask");

endmodule : mask_decode

// ### sticky_flags.sv
// Scaling and limit sticky flags with set-over-clear priority
`timescale 1ns/1ps
module sticky_flags
  import sr_flags_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  status_if.flg     st
);

  logic nxt_s;
  logic nxt_l;

  // A set in the clearing cycle survives; processor reset clears both
  assign nxt_s = st.s_set | (st.s_flag & ~st.s_clr);
  assign nxt_l = st.l_set | (st.l_flag & ~st.l_clr);

  always_ff @(posedge sys_clk) begin
    if (rst || st.soft_rst) begin
      st.s_flag <= 1'b0;
      st.l_flag <= 1'b0;
    end else begin
      st.s_flag <= nxt_s;
      st.l_flag <= nxt_l;
    end
  end

  a_scale_sticky : assert property (
    @(posedge sys_clk) disable iff (rst)
    st.s_flag && !st.s_clr && !st.soft_rst |=> st.s_flag)
    else $error("scaling flag dropped without a clear");

  a_limit_latch : assert property (
    @(posedge sys_clk) disable iff (rst)
    $fell(st.l_flag) |-> $past(st.l_clr) || $past(st.soft_rst))
    else $error("limit flag fell without clear or reset");

endmodule : sticky_flags

// ### status_flags_bench.sv
// Self-checking bench for the status mask decode and sticky scaling and limit flags
`timescale 1ns/1ps
module status_flags_bench;
  import sr_flags_pkg::*;

  logic              sys_clk   = 1'b0;
  logic              rst       = 1'b1;
  logic              proc_rst  = 1'b0;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [ACC_W-1:0]  acc_a     = '0;
  logic [ACC_W-1:0]  acc_b     = '0;
  logic              mv_x      = 1'b0;
  logic              mv_y      = 1'b0;
  logic              acc_rd    = 1'b0;
  logic              lim_act   = 1'b0;
  logic              ovf       = 1'b0;
  logic              sat_ev    = 1'b0;
  logic              irq;
  logic [3:0]        epl;
  logic              mlh;
  logic              mll;
  logic              ssh;
  logic              ssl;
  logic              sat_mode;
  logic              scale_flag;
  logic              limit_flag;
  int                bad_count  = 0;
  int                n_compared = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 125 MHz
  always #4 sys_clk = ~sys_clk;

  // Device under test
  status_flags status_flags_inst (
    .sys_clk(sys_clk), .rst(rst), .proc_rst(proc_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc_a(acc_a), .acc_b(acc_b),
    .move_x_side_data_bus(mv_x), .move_y_side_data_bus(mv_y), .acc_read(acc_rd),
    .limiter_active(lim_act), .overflow_flag(ovf), .sat_event(sat_ev),
    .irq(irq), .exception_priority_level(epl), .mask_level_high(mlh),
    .mask_level_low(mll), .scale_select_high(ssh), .scale_select_low(ssl),
    .sat_mode(sat_mode), .scale_flag(scale_flag), .limit_flag(limit_flag)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; four-state compare so an unknown never matches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle write; ends just after the taking edge so its effect is visible
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // One-cycle datapath event: c = {move x, move y, acc read, limiter, overflow, saturation}
  task automatic fire(input logic [5:0] c, input logic [3:0] a, input logic [3:0] b);
    @(posedge sys_clk);
    {mv_x, mv_y, acc_rd, lim_act, ovf, sat_ev} <= c;
    acc_a <= {8'h00, a, 44'h0};
    acc_b <= {8'h00, b, 44'h0};
    @(posedge sys_clk);
    {mv_x, mv_y, acc_rd, lim_act, ovf, sat_ev} <= 6'h00;
    #1;
  endtask : fire

  // Verdict and the single end of the run
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin : main
    logic [31:0] d;
    static logic [3:0] perm [4] = '{4'hf, 4'he, 4'hc, 4'h8};
    static logic [3:0] miss [4] = '{4'h9, 4'hd, 4'hb, 4'h5};
    static logic [5:0] lcause [6] = '{6'h02, 6'h0c, 6'h24, 6'h08, 6'h01, 6'h01};
    static logic       lsat [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    static logic       lexp [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset state, unmapped and read-only places
    rd(OFS_SR, d);
    check("sr after reset", d, 32'h300);
    check("permit after reset", {28'h0, epl}, 32'h8);
    rd(8'h18, d);
    check("unmapped read", d, 32'h0);
    wr(OFS_PERM, 32'h0);
    rd(OFS_PERM, d);
    check("permit ro", d, 32'h8);
    // Every mask code; permit lands one cycle after the mask
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SR, 32'(m) << MASK_LO);
      @(posedge sys_clk);
      #1;
      check("permit", {28'h0, epl}, {28'h0, perm[m]});
      check("mask bits", {30'h0, mlh, mll}, 32'(m));
    end
    // Scaling flag in each mode; miss patterns hit in the other modes only
    wr(OFS_IMSK, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SR, (32'(m) << SEL_LO) | 32'h300);
      check("select bits", {30'h0, ssh, ssl}, 32'(m));
      wr(OFS_FCLR, 32'h80);
      wr(OFS_IST, 32'h3);
      fire(6'h00, 4'h5, 4'h5);
      check("scale no move", {31'h0, scale_flag}, 32'h0);
      fire(6'h20, miss[m], 4'h0);
      check("scale miss", {31'h0, scale_flag}, 32'h0);
      fire(6'h10, 4'h0, 4'h5);
      check("scale hit", {31'h0, scale_flag}, 32'(m != 3));
      check("irq scale", {31'h0, irq}, 32'(m != 3));
      fire(6'h20, 4'h0, 4'h0);
      check("scale sticky", {31'h0, scale_flag}, 32'(m != 3));
      wr(OFS_FCLR, 32'h80);
      check("scale clear", {31'h0, scale_flag}, 32'h0);
      wr(OFS_IST, 32'h1);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
    // Limit flag causes; the pair of saturation cases differs only in mode
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CFG, {31'h0, lsat[i]});
      fire(lcause[i], 4'h0, 4'h0);
      check("limit set", {31'h0, limit_flag}, {31'h0, lexp[i]});
      check("irq masked", {31'h0, irq}, 32'h0);
      fire(6'h00, 4'h0, 4'h0);
      check("limit held", {31'h0, limit_flag}, {31'h0, lexp[i]});
      wr(OFS_FCLR, 32'h40);
      check("limit clear", {31'h0, limit_flag}, 32'h0);
    end
    check("sat mode", {31'h0, sat_mode}, 32'h1);
    // Interrupt status, mask and write-one-to-clear
    rd(OFS_IST, d);
    check("int status", d, 32'h2);
    wr(OFS_IMSK, 32'h3);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr(OFS_IST, 32'h2);
    check("irq w1c", {31'h0, irq}, 32'h0);
    // Processor reset clears both flags but keeps mask and select
    wr(OFS_SR, 32'h500);
    fire(6'h22, 4'h5, 4'h0);
    rd(OFS_SR, d);
    check("sr flags", d, 32'h5c0);
    @(posedge sys_clk);
    proc_rst <= 1'b1;
    @(posedge sys_clk);
    proc_rst <= 1'b0;
    #1;
    check("flags proc rst", {30'h0, scale_flag, limit_flag}, 32'h0);
    rd(OFS_SR, d);
    check("sr proc rst", d, 32'h500);
    check("permit proc rst", {28'h0, epl}, 32'he);
    check("select proc rst", {30'h0, ssh, ssl}, 32'h1);
    // Hardware reset brings the mask back to the highest level
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_SR, d);
    check("sr hw rst", d, 32'h300);
    check("sat hw rst", {31'h0, sat_mode}, 32'h0);
    print_verdict();
  end : main

  // Watchdog; the sequence needs well under two thousand cycles
  initial begin : watchdog
    #100000;
    bad_count++;
    print_verdict();
  end : watchdog

endmodule : status_flags_bench
